/* include/emr_defines.vh */
/*
 * Constants for the external memory bus release block: release state
 * codes, interface clock select codes, divider counts and handshake
 * latencies counted in interface clock periods.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef EMR_DEFINES_VH
`define EMR_DEFINES_VH

// release state machine codes
`define EMR_ST_DRIVE    3'h0
`define EMR_ST_PREP     3'h1
`define EMR_ST_FLOATED  3'h2
`define EMR_ST_GRANTED  3'h3
`define EMR_ST_REDRIVE  3'h4

// interface input clock select
`define EMR_CLKSEL_EXT_MEM_CLOCK_IN 2'h0
`define EMR_CLKSEL_DIV4   2'h1
`define EMR_CLKSEL_DIV6   2'h2

// core clock divider periods and their high phase
`define EMR_DIV4_CNT    3'h4
`define EMR_DIV6_CNT    3'h6
`define EMR_DIV4_HALF   3'h2
`define EMR_DIV6_HALF   3'h3

// handshake latencies in interface clock periods
`define EMR_FLOAT_MIN_E   2
`define EMR_DRIVE_MIN_E   2
`define EMR_DRIVE_MAX_E   7
`define EMR_GRANT_MAX_E   2
`define EMR_HOLD_AFTER_E  1

// reset levels
`define EMR_REQ_IDLE    1'h1
`define EMR_GRANT_IDLE  1'h1

`endif

/* hw/emr_iclk_gen.v */
/*
 * Interface input clock generator: derives the interface clock level
 * and a one-cycle tick at each of its rising edges from the core clock,
 * either from the sampled external clock input or by dividing by 4 or 6.
 * Assumes the external clock input is synchronous to the core clock and
 * slower than half of it.
 */
`timescale 1ns/1ps
`include "emr_defines.vh"

module emr_iclk_gen (
    input  wire       clk,      // core clock
    input  wire       rst_n,    // synchronous reset, active low
    input  wire [1:0] sel,      // interface clock select
    input  wire       eclk_in,  // external interface clock input
    output reg        lvl_r,    // interface clock level
    output reg        tick_r    // pulse with each rising edge of lvl_r
);

    reg  [2:0] cnt_r;
    reg  [2:0] cnt_nxt;
    reg        lvl_nxt;
    wire [2:0] period;
    wire [2:0] half;

    // reserved select code falls back to divide by four
    assign period = (sel == `EMR_CLKSEL_DIV6) ? `EMR_DIV6_CNT : `EMR_DIV4_CNT;
    assign half   = (sel == `EMR_CLKSEL_DIV6) ? `EMR_DIV6_HALF
                                              : `EMR_DIV4_HALF;

    always @* begin
        cnt_nxt = (cnt_r >= period - 3'h1) ? 3'h0 : cnt_r + 3'h1;
        if (sel == `EMR_CLKSEL_EXT_MEM_CLOCK_IN) begin
            lvl_nxt = eclk_in;
        end else begin
            lvl_nxt = (cnt_r < half);
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            cnt_r  <= 3'h0;
            lvl_r  <= 1'h0;
            tick_r <= 1'h0;
        end else begin
            cnt_r  <= cnt_nxt;
            lvl_r  <= lvl_nxt;
            tick_r <= lvl_nxt & ~lvl_r;
        end
    end

endmodule // emr_iclk_gen

/* hw/emr_bus_release.v */
/*
 * Bus release handshake for two external memory interfaces: a wide one
 * (index 0, prefix A) and a narrow one (index 1, prefix B). An outside
 * master requests the bus; pending work finishes, the bus floats, and
 * the grant follows. Withdrawal drives the bus again first, then the grant rises.
 * Assumes the memory engine raises XFER_BUSY while an access runs and
 * starts no new access while NEW_ACCESS_HOLD is high.
 */
// Notes on behaviour
// RULE_01: pending memory accesses finish before the grant goes low.
// RULE_02: the bus floats at least two periods after the request falls.
// RULE_03: the grant falls only once the bus floats, within two periods.
// RULE_04: the outside master holds the request low one period past grant.
// RULE_05: the bus is driven again 2 to 7 periods after the request rises.
// RULE_06: the grant rises only once the bus is driven, within two periods.
// RULE_07: while released the clock output runs, or floats if selected.
// RULE_08: a floated clock output shares the bus float and drive timing.
// RULE_09: with the refusal bit set the bus is neither floated nor granted.
// RULE_10: the wide side floats all address, data, control and strobe pins.
// RULE_11: the narrow side floats its own pin set, which has no clock enable.
// RULE_12: the pending flag changes only after a rising clock output edge.
// RULE_13: all latencies count periods of the selected interface clock.
// RULE_14: the request passes two interface clock flip-flops before use.
`timescale 1ns/1ps
`include "emr_defines.vh"

module emr_bus_release (
    input  wire        MCLK,                    // core clock, 100 MHz
    input  wire        RESET_N,                 // synchronous reset
    input  wire [1:0]  A_CLK_SEL,               // wide clock select
    input  wire        A_EXT_MEM_CLOCK_IN,      // wide external clock
    input  wire        A_BUS_RELEASE_REQUEST_N, // wide release request
    input  wire        A_RELEASE_REFUSAL,       // wide refuse release
    input  wire        A_CLKOUT_FLOAT_SELECT,   // wide clock float
    input  wire        A_XFER_BUSY,             // wide access running
    output wire        A_BUS_RELEASE_GRANT_N,   // wide grant
    output wire        A_ACCESS_PENDING_FLAG,   // wide pending flag
    output wire        A_NEW_ACCESS_HOLD,       // wide stall new access
    output wire        A_EXT_MEM_CLOCK_OUT,     // wide clock out
    output wire        A_EXT_MEM_CLOCK_OUT_OE,  // wide clock out enable
    output wire [3:0]  A_CS_OE,                 // wide chip selects
    output wire [7:0]  A_BE_OE,                 // wide byte enables
    output wire [63:0] A_DATA_OE,               // wide data lines
    output wire [22:3] A_ADDR_OE,               // wide address lines
    output wire [2:0]  A_STROBE_OE,             // wide strobes
    output wire        A_SDRAM_CLK_EN_OUT_OE,   // wide sdram clk en
    output wire        A_OE3_OE,                // wide third oe
    output wire        A_DIRECT_TRANSFER_STROBE_OE, // wide xfer strobe
    input  wire [1:0]  B_CLK_SEL,               // narrow clock select
    input  wire        B_EXT_MEM_CLOCK_IN,      // narrow external clock
    input  wire        B_BUS_RELEASE_REQUEST_N, // narrow release request
    input  wire        B_RELEASE_REFUSAL,       // narrow refuse release
    input  wire        B_CLKOUT_FLOAT_SELECT,   // narrow clock float
    input  wire        B_XFER_BUSY,             // narrow access running
    output wire        B_BUS_RELEASE_GRANT_N,   // narrow grant
    output wire        B_ACCESS_PENDING_FLAG,   // narrow pending flag
    output wire        B_NEW_ACCESS_HOLD,       // narrow stall new access
    output wire        B_EXT_MEM_CLOCK_OUT,     // narrow clock out
    output wire        B_EXT_MEM_CLOCK_OUT_OE,  // narrow clock out enable
    output wire [3:0]  B_CS_OE,                 // narrow chip selects
    output wire [1:0]  B_BE_OE,                 // narrow byte enables
    output wire [15:0] B_DATA_OE,               // narrow data lines
    output wire [20:1] B_ADDR_OE,               // narrow address lines
    output wire [2:0]  B_STROBE_OE,             // narrow strobes
    output wire        B_OE3_OE,                // narrow third oe
    output wire        B_DIRECT_TRANSFER_STROBE_OE // narrow xfer strobe
);

    // next release state; only called on an interface clock tick
    function [2:0] rel_next;
        input [2:0] st;
        input       req_n;
        input       refuse;
        input       busy;
        begin
            case (st)
                `EMR_ST_DRIVE: begin
                    if (!req_n && !refuse && !busy) begin // RULE_01 RULE_09
                        rel_next = `EMR_ST_PREP;
                    end else begin
                        rel_next = `EMR_ST_DRIVE;
                    end
                end
                `EMR_ST_PREP: begin
                    // a late refusal or withdrawn request cancels the release
                    if (req_n || refuse) begin // RULE_09
                        rel_next = `EMR_ST_DRIVE;
                    end else begin
                        rel_next = `EMR_ST_FLOATED; // RULE_02
                    end
                end
                `EMR_ST_FLOATED: begin
                    rel_next = `EMR_ST_GRANTED; // RULE_03
                end
                `EMR_ST_GRANTED: begin
                    // the master holds the request low past the grant
                    if (req_n) begin // RULE_04 RULE_05
                        rel_next = `EMR_ST_REDRIVE;
                    end else begin
                        rel_next = `EMR_ST_GRANTED;
                    end
                end
                `EMR_ST_REDRIVE: begin
                    rel_next = `EMR_ST_DRIVE; // RULE_06
                end
                default: begin
                    rel_next = `EMR_ST_DRIVE;
                end
            endcase
        end
    endfunction

    // bus and, if selected, clock output are released in these states
    function bus_off;
        input [2:0] st;
        begin
            bus_off = (st == `EMR_ST_FLOATED) || (st == `EMR_ST_GRANTED);
        end
    endfunction

    // grant stays low through redrive so it trails the bus coming back
    function grant_on;
        input [2:0] st;
        begin
            grant_on = (st == `EMR_ST_GRANTED) || (st == `EMR_ST_REDRIVE);
        end
    endfunction

    wire [3:0] clk_sel_w;
    wire [1:0] eclk_in_w;
    wire [1:0] req_n_w;
    wire [1:0] refuse_w;
    wire [1:0] float_sel_w;
    wire [1:0] busy_w;
    wire [1:0] lvl_w;
    wire [1:0] tick_w;
    wire [1:0] bus_oe_w;
    wire [1:0] grant_n_w;
    wire [1:0] pend_w;
    wire [1:0] hold_w;
    wire [1:0] ckoe_w;

    assign clk_sel_w   = {B_CLK_SEL, A_CLK_SEL};
    assign eclk_in_w   = {B_EXT_MEM_CLOCK_IN, A_EXT_MEM_CLOCK_IN};
    assign req_n_w     = {B_BUS_RELEASE_REQUEST_N, A_BUS_RELEASE_REQUEST_N};
    assign refuse_w    = {B_RELEASE_REFUSAL, A_RELEASE_REFUSAL};
    assign float_sel_w = {B_CLKOUT_FLOAT_SELECT, A_CLKOUT_FLOAT_SELECT};
    assign busy_w      = {B_XFER_BUSY, A_XFER_BUSY};

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_if
            reg  [2:0] state_r;
            reg  [2:0] state_nxt;
            reg        req_meta_r;
            reg        req_sync_r;
            reg        oe_r;
            reg        grant_n_r;
            reg        ckoe_r;
            reg        pend_r;
            wire       rel_soon;

            emr_iclk_gen i_emr_iclk_gen (
                .clk     (MCLK),
                .rst_n   (RESET_N),
                .sel     (clk_sel_w[2*i+1:2*i]),
                .eclk_in (eclk_in_w[i]),
                .lvl_r   (lvl_w[i]),
                .tick_r  (tick_w[i])
            );

            always @* begin
                if (tick_w[i]) begin // RULE_13
                    state_nxt = rel_next(state_r, req_sync_r, refuse_w[i],
                                         busy_w[i]);
                end else begin
                    state_nxt = state_r;
                end
            end

            always @(posedge MCLK) begin
                if (!RESET_N) begin
                    state_r    <= `EMR_ST_DRIVE;
                    req_meta_r <= `EMR_REQ_IDLE;
                    req_sync_r <= `EMR_REQ_IDLE;
                    oe_r       <= 1'h1;
                    grant_n_r  <= `EMR_GRANT_IDLE;
                    ckoe_r     <= 1'h1;
                    pend_r     <= 1'h0;
                end else begin
                    state_r <= state_nxt;
                    if (tick_w[i]) begin
                        req_meta_r <= req_n_w[i]; // RULE_14
                        req_sync_r <= req_meta_r; // RULE_14
                        // tick coincides with the clock output rising
                        pend_r     <= busy_w[i]; // RULE_12
                    end
                    oe_r      <= !bus_off(state_nxt); // RULE_02 RULE_05
                    grant_n_r <= !grant_on(state_nxt); // RULE_03 RULE_06
                    ckoe_r    <= !(float_sel_w[i] && // RULE_07 RULE_08
                                   bus_off(state_nxt));
                end
            end

            // stall new accesses as soon as a release is on its way, so
            // the drain in the drive state cannot be starved
            assign rel_soon  = !req_sync_r && !refuse_w[i];
            assign hold_w[i] = (state_r != `EMR_ST_DRIVE) || // RULE_01
                               rel_soon;

            assign bus_oe_w[i]  = oe_r;
            assign grant_n_w[i] = grant_n_r;
            assign pend_w[i]    = pend_r;
            assign ckoe_w[i]    = ckoe_r;
        end
    endgenerate

    assign A_BUS_RELEASE_GRANT_N  = grant_n_w[0];
    assign A_ACCESS_PENDING_FLAG  = pend_w[0];
    assign A_NEW_ACCESS_HOLD      = hold_w[0];
    assign A_EXT_MEM_CLOCK_OUT    = lvl_w[0];
    assign A_EXT_MEM_CLOCK_OUT_OE = ckoe_w[0];

    // wide floated set
    assign A_CS_OE                     = {4{bus_oe_w[0]}};  // RULE_10
    assign A_BE_OE                     = {8{bus_oe_w[0]}};  // RULE_10
    assign A_DATA_OE                   = {64{bus_oe_w[0]}}; // RULE_10
    assign A_ADDR_OE                   = {20{bus_oe_w[0]}}; // RULE_10
    assign A_STROBE_OE                 = {3{bus_oe_w[0]}};  // RULE_10
    assign A_SDRAM_CLK_EN_OUT_OE       = bus_oe_w[0];       // RULE_10
    assign A_OE3_OE                    = bus_oe_w[0];       // RULE_10
    assign A_DIRECT_TRANSFER_STROBE_OE = bus_oe_w[0];       // RULE_10

    assign B_BUS_RELEASE_GRANT_N  = grant_n_w[1];
    assign B_ACCESS_PENDING_FLAG  = pend_w[1];
    assign B_NEW_ACCESS_HOLD      = hold_w[1];
    assign B_EXT_MEM_CLOCK_OUT    = lvl_w[1];
    assign B_EXT_MEM_CLOCK_OUT_OE = ckoe_w[1];

    // narrow floated set, no sdram clock enable on this side
    assign B_CS_OE                     = {4{bus_oe_w[1]}};  // RULE_11
    assign B_BE_OE                     = {2{bus_oe_w[1]}};  // RULE_11
    assign B_DATA_OE                   = {16{bus_oe_w[1]}}; // RULE_11
    assign B_ADDR_OE                   = {20{bus_oe_w[1]}}; // RULE_11
    assign B_STROBE_OE                 = {3{bus_oe_w[1]}};  // RULE_11
    assign B_OE3_OE                    = bus_oe_w[1];       // RULE_11
    assign B_DIRECT_TRANSFER_STROBE_OE = bus_oe_w[1];       // RULE_11

endmodule // emr_bus_release

/* sim/emr_assertions.sv */
/* Checker for the bus release block: wide side timing, both pin groups.
 * Assumes A_CLK_SEL picks the core clock divided by four, so E = 4. */
`timescale 1ns/1ps
module emr_assertions (
    input wire        MCLK,                    // core clock
    input wire        RESET_N,                 // sync reset
    input wire        A_BUS_RELEASE_REQUEST_N, // request
    input wire        A_RELEASE_REFUSAL,       // refuse
    input wire        A_CLKOUT_FLOAT_SELECT,   // clock float
    input wire        A_BUS_RELEASE_GRANT_N,   // grant
    input wire        A_ACCESS_PENDING_FLAG,   // pending
    input wire        A_EXT_MEM_CLOCK_OUT,     // clock out
    input wire        A_EXT_MEM_CLOCK_OUT_OE,  // clock enable
    input wire [3:0]  A_CS_OE,                 // chip selects
    input wire [63:0] A_DATA_OE,               // data
    input wire [22:3] A_ADDR_OE,               // address
    input wire [7:0]  A_BE_OE,                 // byte enables
    input wire [2:0]  A_STROBE_OE,             // strobes
    input wire        A_SDRAM_CLK_EN_OUT_OE,   // sdram clk en
    input wire        A_OE3_OE,                // third oe
    input wire        A_DIRECT_TRANSFER_STROBE_OE, // xfer strobe
    input wire        B_BUS_RELEASE_GRANT_N,   // narrow grant
    input wire [3:0]  B_CS_OE,                 // narrow selects
    input wire [1:0]  B_BE_OE,                 // narrow byte enables
    input wire [15:0] B_DATA_OE,               // narrow data
    input wire [20:1] B_ADDR_OE,               // narrow address
    input wire [2:0]  B_STROBE_OE,             // narrow strobes
    input wire        B_OE3_OE,                // narrow third oe
    input wire        B_DIRECT_TRANSFER_STROBE_OE  // narrow xfer strobe
);
    reg  [3:0] low_cnt_r;
    wire       drv = A_DATA_OE[0];
    wire       drv_b = B_DATA_OE[0];
    // saturates so a long hold never wraps back under the minimum
    always @(posedge MCLK)
        if (!RESET_N || A_BUS_RELEASE_REQUEST_N) low_cnt_r <= 4'h0;
        else if (low_cnt_r != 4'hF) low_cnt_r <= low_cnt_r + 4'h1;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // grant stays low through redrive, so only its edges are ordered
    AST_GRANT_FLOATED: assert property (
        $fell(A_BUS_RELEASE_GRANT_N) |-> !drv)
        else $error("grant fell while bus driven");
    AST_UNGRANT_DRIVEN: assert property (
        $rose(A_BUS_RELEASE_GRANT_N) |-> drv)
        else $error("grant rose while bus floated");
    AST_FLOAT_MIN: assert property (
        $fell(drv) |-> low_cnt_r >= 4'h8)
        else $error("bus floated too early");
    AST_GRANT_SOON: assert property (
        $fell(drv) |-> ##[0:8] !A_BUS_RELEASE_GRANT_N)
        else $error("grant late after float");
    AST_DRIVE_MIN: assert property (
        $rose(A_BUS_RELEASE_REQUEST_N) && !drv |-> !drv [*8])
        else $error("bus driven too early");
    AST_DRIVE_MAX: assert property (
        $rose(A_BUS_RELEASE_REQUEST_N) && !drv |-> ##[1:28] drv)
        else $error("bus driven too late");
    AST_UNGRANT_SOON: assert property (
        $rose(drv) |-> ##[0:8] A_BUS_RELEASE_GRANT_N)
        else $error("grant held too long");
    AST_REFUSE: assert property (
        A_RELEASE_REFUSAL && $past(A_RELEASE_REFUSAL, 2) && drv |=> drv)
        else $error("bus floated while refused");
    AST_CLK_FLOATS: assert property (
        A_CLKOUT_FLOAT_SELECT && $stable(A_CLKOUT_FLOAT_SELECT) |->
        A_EXT_MEM_CLOCK_OUT_OE == drv)
        else $error("clock enable differs from bus");
    AST_CLK_RUNS: assert property (
        !drv && !A_CLKOUT_FLOAT_SELECT |->
        A_EXT_MEM_CLOCK_OUT_OE ##[1:3] $changed(A_EXT_MEM_CLOCK_OUT))
        else $error("clock out stopped");
    AST_PEND_EDGE: assert property (
        $changed(A_ACCESS_PENDING_FLAG) |-> A_EXT_MEM_CLOCK_OUT)
        else $error("pending changed off clock edge");
    AST_WIDE_SET: assert property (
        A_DATA_OE == {64{drv}} && A_ADDR_OE == {20{drv}} &&
        A_CS_OE == {4{drv}} && A_BE_OE == {8{drv}} &&
        A_STROBE_OE == {3{drv}} && A_SDRAM_CLK_EN_OUT_OE == drv &&
        A_OE3_OE == drv && A_DIRECT_TRANSFER_STROBE_OE == drv)
        else $error("bus enables disagree");
    AST_NARROW_SET: assert property (
        B_DATA_OE == {16{drv_b}} && B_ADDR_OE == {20{drv_b}} &&
        B_CS_OE == {4{drv_b}} && B_BE_OE == {2{drv_b}} &&
        B_STROBE_OE == {3{drv_b}} && B_OE3_OE == drv_b &&
        B_DIRECT_TRANSFER_STROBE_OE == drv_b)
        else $error("narrow bus enables disagree");
    AST_B_GRANT_FLOATED: assert property (
        $fell(B_BUS_RELEASE_GRANT_N) |-> !drv_b)
        else $error("narrow grant fell while bus driven");
    C_FLOAT_CLK: cover property ($fell(drv) && A_CLKOUT_FLOAT_SELECT);
    C_REFUSED: cover property (A_RELEASE_REFUSAL && !A_BUS_RELEASE_REQUEST_N);
    C_KEEP_CLK: cover property (!drv && !A_CLKOUT_FLOAT_SELECT);
    C_NARROW_GRANT: cover property (!B_BUS_RELEASE_GRANT_N && !drv_b);
endmodule // emr_assertions

bind emr_bus_release emr_assertions i_emr_assertions (
    .MCLK, .RESET_N, .A_BUS_RELEASE_REQUEST_N, .A_RELEASE_REFUSAL,
    .A_CLKOUT_FLOAT_SELECT, .A_BUS_RELEASE_GRANT_N, .A_ACCESS_PENDING_FLAG,
    .A_EXT_MEM_CLOCK_OUT, .A_EXT_MEM_CLOCK_OUT_OE, .A_CS_OE, .A_BE_OE,
    .A_DATA_OE, .A_ADDR_OE, .A_STROBE_OE, .A_SDRAM_CLK_EN_OUT_OE,
    .A_OE3_OE, .A_DIRECT_TRANSFER_STROBE_OE, .B_BUS_RELEASE_GRANT_N,
    .B_CS_OE, .B_BE_OE, .B_DATA_OE, .B_ADDR_OE, .B_STROBE_OE, .B_OE3_OE,
    .B_DIRECT_TRANSFER_STROBE_OE);

/* sim/emr_master_model.sv */
/* Outside bus master: asks for the memory bus when told, gives it back
 * once the grant has stood for a chosen count after want falls. Assumes linger >= one E. */
`timescale 1ns/1ps
module emr_master_model (
    input  wire       clk,     // core clock
    input  wire       want,    // bench asks for the bus
    input  wire [7:0] linger,  // granted cycles kept after want falls
    input  wire       grant_n, // grant from device
    output reg        req_n    // release request
);
    reg [7:0] held_r = 8'h00;
    initial req_n = 1'b1;
    // an ungranted request is dropped at once, a granted one is kept
    always @(posedge clk) begin
        if (want) begin
            req_n  <= 1'b0;
            held_r <= 8'h00;
        end else if (grant_n) begin
            req_n  <= 1'b1;
        end else if (held_r >= linger) begin
            req_n  <= 1'b1;
        end else begin
            held_r <= held_r + 8'h01;
        end
    end
endmodule // emr_master_model

/* sim/emr_bus_release_test.sv */
/* Testbench for the bus release block with two outside master models.
 * Assumes wide side at core clock / 4, narrow side at / 6. */
`timescale 1ns/1ps
module emr_bus_release_test;
    reg        clk = 1'b0, rst_n = 1'b0, eclk = 1'b0, on_b = 1'b0;
    reg        want_a = 1'b0, want_b = 1'b0, ref_a = 1'b0, ref_b = 1'b0;
    reg        fs_a = 1'b0, fs_b = 1'b0, bz_a = 1'b0, bz_b = 1'b0;
    reg  [1:0] sel_a = 2'h1, sel_b = 2'h2;
    reg  [7:0] lin = 8'h05;
    wire       rq_a, rq_b, g_a, g_b, p_a, p_b, h_a, h_b;
    wire       ck_a, ck_b, co_a, co_b;
    wire [63:0] d_a;
    wire [15:0] d_b;
    integer    n_fail = 0, samples_checked = 0;
    wire [6:0] mon = on_b ? {h_b, p_b, g_b, d_b[0], rq_b, ck_b, co_b}
                          : {h_a, p_a, g_a, d_a[0], rq_a, ck_a, co_a};
    always #5 clk = ~clk;
    always #50 eclk = ~eclk;
    emr_master_model i_emr_master_model_a (.clk(clk), .want(want_a),
        .linger(lin), .grant_n(g_a), .req_n(rq_a));
    emr_master_model i_emr_master_model_b (.clk(clk), .want(want_b),
        .linger(lin), .grant_n(g_b), .req_n(rq_b));
    emr_bus_release i_emr_bus_release (
        .MCLK(clk), .RESET_N(rst_n), .A_CLK_SEL(sel_a), .B_CLK_SEL(sel_b),
        .A_EXT_MEM_CLOCK_IN(eclk), .B_EXT_MEM_CLOCK_IN(eclk),
        .A_BUS_RELEASE_REQUEST_N(rq_a), .B_BUS_RELEASE_REQUEST_N(rq_b),
        .A_RELEASE_REFUSAL(ref_a), .B_RELEASE_REFUSAL(ref_b),
        .A_CLKOUT_FLOAT_SELECT(fs_a), .B_CLKOUT_FLOAT_SELECT(fs_b),
        .A_XFER_BUSY(bz_a), .B_XFER_BUSY(bz_b),
        .A_BUS_RELEASE_GRANT_N(g_a), .B_BUS_RELEASE_GRANT_N(g_b),
        .A_ACCESS_PENDING_FLAG(p_a), .B_ACCESS_PENDING_FLAG(p_b),
        .A_NEW_ACCESS_HOLD(h_a), .B_NEW_ACCESS_HOLD(h_b),
        .A_EXT_MEM_CLOCK_OUT(ck_a), .B_EXT_MEM_CLOCK_OUT(ck_b),
        .A_EXT_MEM_CLOCK_OUT_OE(co_a), .B_EXT_MEM_CLOCK_OUT_OE(co_b),
        .A_CS_OE(), .B_CS_OE(), .A_BE_OE(), .B_BE_OE(),
        .A_DATA_OE(d_a), .B_DATA_OE(d_b), .A_ADDR_OE(), .B_ADDR_OE(),
        .A_STROBE_OE(), .B_STROBE_OE(), .A_SDRAM_CLK_EN_OUT_OE(),
        .A_OE3_OE(), .B_OE3_OE(), .A_DIRECT_TRANSFER_STROBE_OE(),
        .B_DIRECT_TRANSFER_STROBE_OE());
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // bounded wait for one monitored bit, counting edges
    task wt(input integer k, input lvl, output integer n);
        begin
            n = 0;
            while (mon[k] !== lvl && n < 400) begin
                @(posedge clk);
                n = n + 1;
            end
        end
    endtask
    task t_hold(input b, input fsel, input integer bz, input integer e);
        integer n;
        reg     prev;
        begin
            @(posedge clk);
            on_b <= b;
            fs_a <= fsel;
            fs_b <= fsel;
            bz_a <= !b && bz > 0;
            bz_b <= b && bz > 0;
            want_a <= !b;
            want_b <= b;
            repeat (bz) @(posedge clk);
            chk(mon[4:3], 2'h3);
            if (bz > 0) chk(mon[5], 1'b1);
            bz_a <= 1'b0;
            bz_b <= 1'b0;
            wt(3, 1'b0, n);
            if (bz == 0) chk(n >= 2 * e + 2, 1'b1);
            wt(4, 1'b0, n);
            chk(n <= 2 * e, 1'b1);
            chk(mon[6], 1'b1);
            chk(mon[0], !fsel);
            prev = mon[1];
            repeat (e / 2) @(posedge clk);
            if (!fsel) chk(mon[1], !prev);
            want_a <= 1'b0;
            want_b <= 1'b0;
            wt(2, 1'b1, n);
            wt(3, 1'b1, n);
            chk(n >= 2 * e && n <= 7 * e, 1'b1);
            chk(mon[0], 1'b1);
            wt(4, 1'b1, n);
            chk(n <= 2 * e, 1'b1);
            $display("hold test done");
        end
    endtask
    task t_refuse;
        begin
            @(posedge clk);
            on_b <= 1'b0;
            ref_a <= 1'b1;
            repeat (3) @(posedge clk);
            want_a <= 1'b1;
            repeat (80) @(posedge clk);
            chk(mon[4:3], 2'h3);
            chk(mon[6], 1'b0);
            want_a <= 1'b0;
            repeat (40) @(posedge clk);
            ref_a <= 1'b0;
            $display("refusal test done");
        end
    endtask
    task t_clksel;
        integer i, a, n;
        begin
            @(posedge clk);
            on_b <= 1'b1;
            for (i = 0; i < 4; i = i + 1) begin
                sel_b <= i[1:0];
                repeat (40) @(posedge clk);
                wt(1, 1'b0, a);
                wt(1, 1'b1, a);
                wt(1, 1'b0, a);
                wt(1, 1'b1, n);
                chk(a + n, i == 0 ? 10 : i == 2 ? 6 : 4);
            end
            sel_b <= 2'h2;
            repeat (40) @(posedge clk);
            $display("clock select test done");
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        n_fail = n_fail + 1;
        print_verdict;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        chk({g_a, g_b, d_a[0], d_b[0], co_a, co_b, p_a}, 7'h7E);
        t_hold(1'b0, 1'b0, 0, 4);
        t_hold(1'b0, 1'b1, 12, 4);
        t_hold(1'b1, 1'b1, 12, 6);
        lin <= 8'h20;
        t_hold(1'b1, 1'b0, 0, 6);
        t_refuse;
        t_clksel;
        print_verdict;
    end
endmodule // emr_bus_release_test
